// [src/cvrsc_cfg.svh]
// Offsets, field positions, reset values and timing counts of the range controller
`ifndef CVRSC_CFG_SVH
`define CVRSC_CFG_SVH
// ==========================================================
// Register map
`define CVRSC_CTRL_OFS 12'h000
`define CVRSC_STAT_OFS 12'h004
// CTRL fields
`define CVRSC_CTRL_RATE_MSB 2
`define CVRSC_CTRL_FHI 3
`define CVRSC_CTRL_AUTO 4
`define CVRSC_CTRL_ATT 5
// STAT fields
`define CVRSC_STAT_ATT 3
`define CVRSC_STAT_AUTO 4
`define CVRSC_STAT_CONF 5
`define CVRSC_STAT_COVF 6
`define CVRSC_STAT_GOVF 7
`define CVRSC_STAT_OVLD 8
`define CVRSC_STAT_HRES 9
// ==========================================================
// Reset values
`define CVRSC_RANGE_RST 3'h0
`define CVRSC_RATE_RST 3'h1
// ==========================================================
// Display limits and range bounds
`define CVRSC_LIM_HI 18'sh055EF
`define CVRSC_LIM_LO 18'sh00897
`define CVRSC_RNG_TOP 3'h4
`define CVRSC_RNG_STD_TOP 3'h3
`define CVRSC_RNG_LOW_FHI 3'h1
// ==========================================================
// Timing
`define CVRSC_HOLD_MS 500
`define CVRSC_CLK_NS 5
`define CVRSC_HOLD_CYC (`CVRSC_HOLD_MS * 1000000 / `CVRSC_CLK_NS)
`endif

// [src/cvrsc_pkg.sv]
// Types shared by the range selection controller
package cvrsc_pkg;
  typedef enum logic [2:0] {
    RATE_1 = 3'h0,
    RATE_10 = 3'h1,
    RATE_18 = 3'h2,
    RATE_75 = 3'h3,
    RATE_1000 = 3'h4
  } cvrsc_rate_t;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'h0,
    KEY_HELD = 2'h1,
    KEY_SHIFT = 2'h2,
    KEY_LONG = 2'h3
  } cvrsc_key_t;
  typedef struct packed {
    logic signed [17:0] cap;
    logic signed [17:0] cond;
    logic amp_sat;
    logic auto_up;
    logic auto_down;
  } cvrsc_meas_t;
  typedef struct packed {
    logic auto_led;
    logic atten_led;
    logic test_frequency_key_hi_led;
    logic conflict;
    logic hi_res;
    logic cap_display_overflow_message;
    logic cond_display_overflow_message;
    logic overload;
  } cvrsc_panel_t;
  typedef struct packed {
    logic sweep_abort;
    logic buf_clear;
    logic bias_hold;
    logic buf_hold;
    logic readings_valid;
    logic scale_x10;
  } cvrsc_ctl_t;
endpackage

// [src/cvrsc_top.sv]
// Range, attenuator and autorange control with APB access
//
// Functional notes
// [R01] Five ranges 2pF..20nF at low frequency; 20pF, 200pF, 2nF at high.
// [R02] Lowest range never selected at the high test frequency.
// [R03] Top range only at low frequency with the attenuator on.
// [R04] High resolution at 1, 10, 18 per second; low at 75, 1000.
// [R05] The 18 per second rate is accepted only from the bus.
// [R06] Display limit 21999 counts high resolution, 2199 low.
// [R07] Each reading flagged overflow independently above its limit.
// [R08] Amplifier saturation shows overload and marks both readings invalid.
// [R09] Overload halts bias stepping and buffer storage.
// [R10] Analog outputs carry readings even during overload.
// [R11] Brief range key press steps up exactly one range.
// [R12] Brief press on the highest range wraps to the lowest.
// [R13] Brief press during autorange cancels it and keeps the range.
// [R14] Holding the range key over half a second enables autorange.
// [R15] Autorange never selects the attenuator.
// [R16] Autorange refused at 75 and 1000 per second, conflict raised.
// [R17] Shifted range press toggles the attenuator; its lamp follows.
// [R18] Attenuator on scales readings and shifts ranges up a decade.
// [R19] Conflict on attenuator at high frequency or high frequency with attenuator.
// [R20] Any range, attenuator or autorange change aborts a sweep.
// [R21] Any range change clears the measurement buffer and pointer.
// [R22] A conflicting request leaves all settings unchanged.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "cvrsc_cfg.svh"

module cvrsc_top #(
  parameter int unsigned HOLD_CYC = `CVRSC_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic range_key,
  input wire logic shift_key,
  input wire logic test_frequency_key,
  input wire logic rate_key,
  input wire cvrsc_pkg::cvrsc_meas_t meas,
  output cvrsc_pkg::cvrsc_panel_t panel,
  output cvrsc_pkg::cvrsc_ctl_t ctl,
  output logic [2:0] range_sel,
  output logic signed [17:0] analog_cap,
  output logic signed [17:0] analog_cond
);
  import cvrsc_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);

  // ==========================================================
  // Range bound helpers
  function automatic logic [2:0] rng_lo(input logic fh, input logic at);
    return (fh || at) ? `CVRSC_RNG_LOW_FHI : 3'h0;
  endfunction

  function automatic logic [2:0] rng_hi(input logic fh, input logic at);
    return (!fh && at) ? `CVRSC_RNG_TOP : `CVRSC_RNG_STD_TOP;
  endfunction

  function automatic logic hres(input cvrsc_rate_t r);
    return (r == RATE_1) || (r == RATE_10) || (r == RATE_18);
  endfunction

  // ==========================================================
  // Key synchronisers
  logic [3:0] key_in;
  logic [3:0] key_s1;
  logic [3:0] key_s2;
  logic [3:0] key_dly;

  assign key_in = {rate_key, test_frequency_key, shift_key, range_key};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          key_s1[gi] <= 1'b0;
          key_s2[gi] <= 1'b0;
          key_dly[gi] <= 1'b0;
        end else begin
          key_s1[gi] <= key_in[gi];
          key_s2[gi] <= key_s1[gi];
          key_dly[gi] <= key_s2[gi];
        end
      end
    end
  endgenerate

  logic rng_s;
  logic shift_s;
  logic rng_rise;
  logic test_frequency_key_rise;
  logic rate_rise;

  assign rng_s = key_s2[0];
  assign shift_s = key_s2[1];
  assign rng_rise = key_s2[0] && !key_dly[0];
  assign test_frequency_key_rise = key_s2[2] && !key_dly[2];
  assign rate_rise = key_s2[3] && !key_dly[3];

  // ==========================================================
  // Range key press timing
  cvrsc_key_t key_reg;
  logic [CW-1:0] hold_reg;
  logic brief_ev;
  logic long_ev;
  logic shift_ev;

  assign shift_ev = (key_reg == KEY_IDLE) && rng_rise && shift_s;
  assign brief_ev = (key_reg == KEY_HELD) && !rng_s;
  assign long_ev = (key_reg == KEY_HELD) && rng_s && (hold_reg == CW'(HOLD_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_reg <= KEY_IDLE;
      hold_reg <= '0;
    end else begin
      unique case (key_reg)
        KEY_IDLE: begin
          hold_reg <= '0;
          if (rng_rise) begin
            key_reg <= shift_s ? KEY_SHIFT : KEY_HELD;
          end
        end
        KEY_HELD: begin
          hold_reg <= hold_reg + 1'b1;
          if (!rng_s) begin
            key_reg <= KEY_IDLE; // R11
          end else if (long_ev) begin
            key_reg <= KEY_LONG; // R14
          end
        end
        KEY_SHIFT, KEY_LONG: begin
          if (!rng_s) begin
            key_reg <= KEY_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // APB decode
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic bus_wr;
  logic setup;
  logic hit_ctrl;
  logic hit_stat;

  assign setup = psel && !penable;
  assign hit_ctrl = paddr == `CVRSC_CTRL_OFS;
  assign hit_stat = paddr == `CVRSC_STAT_OFS;
  assign bus_wr = psel && penable && pready_reg && pwrite;

  // ==========================================================
  // Settings state
  logic [2:0] range_reg;
  logic [2:0] range_next;
  logic atten_reg;
  logic atten_next;
  logic auto_reg;
  logic auto_next;
  logic fhi_reg;
  logic fhi_next;
  cvrsc_rate_t rate_reg;
  cvrsc_rate_t rate_next;
  logic conflict_reg;
  logic conf_set;
  logic do_bus;
  logic do_test_frequency_key;
  logic do_shift;
  logic do_long;
  logic do_brief;
  logic do_rate;
  logic do_auto;

  // One request per cycle, bus first
  assign do_bus = bus_wr && hit_ctrl;
  assign do_test_frequency_key = !do_bus && test_frequency_key_rise;
  assign do_shift = !do_bus && !test_frequency_key_rise && shift_ev;
  assign do_long = !do_bus && !test_frequency_key_rise && !shift_ev && long_ev;
  assign do_brief = !do_bus && !test_frequency_key_rise && !shift_ev && !long_ev && brief_ev;
  assign do_rate = !do_bus && !test_frequency_key_rise && !shift_ev && !long_ev && !brief_ev
    && rate_rise;
  assign do_auto = !do_bus && !test_frequency_key_rise && !shift_ev && !long_ev && !brief_ev
    && !rate_rise && auto_reg && (meas.auto_up || meas.auto_down);

  always_comb begin
    logic [2:0] c_rng;
    logic c_att;
    logic c_auto;
    logic c_fhi;
    cvrsc_rate_t c_rate;
    logic [2:0] lo;
    logic [2:0] hi;
    c_rng = range_reg;
    c_att = atten_reg;
    c_auto = auto_reg;
    c_fhi = fhi_reg;
    c_rate = rate_reg;
    lo = rng_lo(fhi_reg, atten_reg);
    hi = rng_hi(fhi_reg, atten_reg);
    if (do_bus) begin
      c_fhi = pwdata[`CVRSC_CTRL_FHI];
      c_auto = pwdata[`CVRSC_CTRL_AUTO];
      c_att = pwdata[`CVRSC_CTRL_ATT];
      if (pwdata[`CVRSC_CTRL_RATE_MSB:0] <= RATE_1000) begin
        c_rate = cvrsc_rate_t'(pwdata[`CVRSC_CTRL_RATE_MSB:0]); // R05
      end
      if (c_att && !atten_reg) begin
        c_rng = range_reg + 3'h1;
      end else if (!c_att && atten_reg) begin
        c_rng = range_reg - 3'h1;
      end
    end else if (do_test_frequency_key) begin
      c_fhi = !fhi_reg;
    end else if (do_shift) begin
      c_att = !atten_reg; // R17
      c_rng = atten_reg ? range_reg - 3'h1 : range_reg + 3'h1; // R18
    end else if (do_long) begin
      c_auto = 1'b1; // R14
    end else if (do_brief) begin
      if (auto_reg) begin
        c_auto = 1'b0; // R13
      end else if (range_reg >= hi) begin
        c_rng = lo; // R12
      end else begin
        c_rng = range_reg + 3'h1; // R11
      end
    end else if (do_rate) begin
      unique case (rate_reg)
        RATE_1: c_rate = RATE_10;
        RATE_10: c_rate = RATE_75;
        RATE_18: c_rate = RATE_75;
        RATE_75: c_rate = RATE_1000;
        RATE_1000: c_rate = RATE_1; // R05
        default: c_rate = RATE_1;
      endcase
    end else if (do_auto) begin
      // Attenuator untouched by autorange
      if (meas.auto_up && range_reg < hi) begin
        c_rng = range_reg + 3'h1; // R15
      end else if (meas.auto_down && !meas.auto_up && range_reg > lo) begin
        c_rng = range_reg - 3'h1; // R15
      end
    end
    conf_set = (c_fhi && c_att) || (c_auto && !hres(c_rate)); // R16 R19
    if (conf_set) begin
      range_next = range_reg; // R22
      atten_next = atten_reg;
      auto_next = auto_reg;
      fhi_next = fhi_reg;
      rate_next = rate_reg;
    end else begin
      lo = rng_lo(c_fhi, c_att);
      hi = rng_hi(c_fhi, c_att);
      // Clamp into the ranges this setup offers
      if (c_rng < lo) begin
        range_next = lo; // R01 R02
      end else if (c_rng > hi) begin
        range_next = hi; // R03
      end else begin
        range_next = c_rng;
      end
      atten_next = c_att;
      auto_next = c_auto;
      fhi_next = c_fhi;
      rate_next = c_rate;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_reg <= `CVRSC_RANGE_RST;
      atten_reg <= 1'b0;
      auto_reg <= 1'b0;
      fhi_reg <= 1'b0;
      rate_reg <= cvrsc_rate_t'(`CVRSC_RATE_RST);
    end else begin
      range_reg <= range_next;
      atten_reg <= atten_next;
      auto_reg <= auto_next;
      fhi_reg <= fhi_next;
      rate_reg <= rate_next;
    end
  end

  // Conflict flag: a new conflict beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conflict_reg <= 1'b0;
    end else if (conf_set) begin
      conflict_reg <= 1'b1; // R16 R19
    end else if (bus_wr && hit_stat && pwdata[`CVRSC_STAT_CONF]) begin
      conflict_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Sweep abort and buffer clear
  logic abort_reg;
  logic bclr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_reg <= 1'b0;
      bclr_reg <= 1'b0;
    end else begin
      abort_reg <= (range_next != range_reg) || (atten_next != atten_reg)
        || (auto_next != auto_reg); // R20
      bclr_reg <= range_next != range_reg; // R21
    end
  end

  // ==========================================================
  // Reading checks
  logic cap_display_overflow_message_reg;
  logic cond_display_overflow_message_reg;
  logic ovld_reg;
  logic valid_reg;
  logic hres_reg;
  logic signed [17:0] lim;
  logic signed [17:0] acap_reg;
  logic signed [17:0] acond_reg;

  assign lim = hres(rate_reg) ? `CVRSC_LIM_HI : `CVRSC_LIM_LO; // R06

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_display_overflow_message_reg <= 1'b0;
      cond_display_overflow_message_reg <= 1'b0;
      hres_reg <= 1'b0;
    end else begin
      cap_display_overflow_message_reg <= meas.cap > lim; // R07
      cond_display_overflow_message_reg <= meas.cond > lim; // R07
      hres_reg <= hres(rate_reg); // R04
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovld_reg <= 1'b0;
      valid_reg <= 1'b1;
    end else begin
      ovld_reg <= meas.amp_sat; // R08 R09
      valid_reg <= !meas.amp_sat; // R08
    end
  end

  // Analog path ignores overload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acap_reg <= '0;
      acond_reg <= '0;
    end else begin
      acap_reg <= meas.cap; // R10
      acond_reg <= meas.cond; // R10
    end
  end

  // ==========================================================
  // APB answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !hit_ctrl && !hit_stat;
      if (setup && hit_ctrl) begin
        prdata_reg <= {26'h0, atten_reg, auto_reg, fhi_reg, rate_reg};
      end else if (setup && hit_stat) begin
        prdata_reg <= {22'h0, hres_reg, ovld_reg, cond_display_overflow_message_reg, cap_display_overflow_message_reg,
          conflict_reg, auto_reg, atten_reg, range_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign range_sel = range_reg;
  assign analog_cap = acap_reg;
  assign analog_cond = acond_reg;
  assign panel = {auto_reg, atten_reg, fhi_reg, conflict_reg, hres_reg, cap_display_overflow_message_reg,
    cond_display_overflow_message_reg, ovld_reg};
  assign ctl = {abort_reg, bclr_reg, ovld_reg, ovld_reg, valid_reg, atten_reg};

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_no_low_at_fhi;
    fhi_reg |-> range_reg != 3'h0;
  endproperty
  a_no_low_at_fhi: assert property (p_no_low_at_fhi) else $error("low range at high test_frequency_key"); // R02

  property p_top_range;
    range_reg == `CVRSC_RNG_TOP |-> !fhi_reg && atten_reg;
  endproperty
  a_top_range: assert property (p_top_range) else $error("top range illegal"); // R03

  property p_fhi_ranges;
    fhi_reg && !atten_reg |-> range_reg inside {[3'h1:3'h3]};
  endproperty
  a_fhi_ranges: assert property (p_fhi_ranges) else $error("bad high test_frequency_key range"); // R01

  property p_hres;
    ##1 $past(presetn) |-> hres_reg == $past(rate_reg inside {RATE_1, RATE_10, RATE_18});
  endproperty
  a_hres: assert property (p_hres) else $error("resolution mismatch"); // R04

  property p_panel_rate;
    do_rate |=> rate_reg != RATE_18;
  endproperty
  a_panel_rate: assert property (p_panel_rate) else $error("panel chose 18/s"); // R05

  property p_cap_display_overflow_message;
    meas.cap > lim |=> panel.cap_display_overflow_message && (panel.cond_display_overflow_message == $past(meas.cond > lim));
  endproperty
  a_cap_display_overflow_message: assert property (p_cap_display_overflow_message) else $error("overflow flag wrong"); // R07

  property p_ovld;
    meas.amp_sat |=> ctl.bias_hold && ctl.buf_hold && !ctl.readings_valid && panel.overload;
  endproperty
  a_ovld: assert property (p_ovld) else $error("overload not handled"); // R09

  property p_analog;
    ##1 analog_cap == $past(meas.cap);
  endproperty
  a_analog: assert property (p_analog) else $error("analog path gated"); // R10

  property p_step;
    do_brief && !auto_reg && range_reg < rng_hi(fhi_reg, atten_reg)
      |=> range_reg == $past(range_reg) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("brief press did not step"); // R11

  property p_wrap;
    do_brief && !auto_reg && range_reg == rng_hi(fhi_reg, atten_reg)
      |=> range_reg == rng_lo(fhi_reg, atten_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // R12

  property p_cancel;
    do_brief && auto_reg |=> !auto_reg && $stable(range_reg);
  endproperty
  a_cancel: assert property (p_cancel) else $error("autorange not cancelled"); // R13

  property p_auto_att;
    do_auto |=> $stable(atten_reg);
  endproperty
  a_auto_att: assert property (p_auto_att) else $error("autorange moved attenuator"); // R15

  property p_auto_refuse;
    do_long && !hres(rate_reg) && !auto_reg |=> !auto_reg && conflict_reg;
  endproperty
  a_auto_refuse: assert property (p_auto_refuse) else $error("autorange accepted"); // R16

  property p_att_conf;
    do_shift && fhi_reg |=> conflict_reg && $stable(atten_reg) && $stable(range_reg);
  endproperty
  a_att_conf: assert property (p_att_conf) else $error("attenuator at high test_frequency_key"); // R19

  property p_abort;
    range_next != range_reg |=> ctl.sweep_abort && ctl.buf_clear;
  endproperty
  a_abort: assert property (p_abort) else $error("range change not flushed"); // R21
endmodule

// [bench/cvrsc_operator.sv]
// Front-panel operator model pressing the panel keys
`timescale 1ns/1ps

module cvrsc_operator (
  input wire logic pclk,
  output logic range_key,
  output logic shift_key,
  output logic test_frequency_key,
  output logic rate_key
);
  initial begin
    range_key = 1'b0;
    shift_key = 1'b0;
    test_frequency_key = 1'b0;
    rate_key = 1'b0;
  end

  // Key 0 range, 1 frequency, 2 rate; shift wraps the press
  task automatic press(input int unsigned which, input int unsigned n, input logic shifted);
    @(posedge pclk);
    shift_key <= shifted;
    @(posedge pclk);
    case (which)
      0: range_key <= 1'b1;
      1: test_frequency_key <= 1'b1;
      default: rate_key <= 1'b1;
    endcase
    repeat (n) @(posedge pclk);
    range_key <= 1'b0;
    test_frequency_key <= 1'b0;
    rate_key <= 1'b0;
    repeat (2) @(posedge pclk);
    shift_key <= 1'b0;
    // Let the synchroniser and state settle
    repeat (8) @(posedge pclk);
  endtask
endmodule

// [bench/test_cvrsc_top.sv]
// Self-checking bench of the range selection controller
`timescale 1ns/1ps

module test_cvrsc_top;
  import cvrsc_pkg::*;
  localparam int unsigned HOLD = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic range_key, shift_key, test_frequency_key, rate_key;
  cvrsc_meas_t meas;
  cvrsc_panel_t panel;
  cvrsc_ctl_t ctl;
  logic [2:0] range_sel;
  logic signed [17:0] analog_cap, analog_cond;
  int n_fail = 0;
  int checks_done = 0;
  int n_clr = 0;
  int n_abort = 0;

  cvrsc_top #(.HOLD_CYC(HOLD)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .range_key(range_key), .shift_key(shift_key),
    .test_frequency_key(test_frequency_key), .rate_key(rate_key), .meas(meas),
    .panel(panel), .ctl(ctl), .range_sel(range_sel), .analog_cap(analog_cap),
    .analog_cond(analog_cond));
  cvrsc_operator op (.pclk(pclk), .range_key(range_key), .shift_key(shift_key),
    .test_frequency_key(test_frequency_key), .rate_key(rate_key));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Pulse counters for sweep abort and buffer clear
  always @(posedge pclk) begin
    if (ctl.buf_clear === 1'b1) n_clr++;
    if (ctl.sweep_abort === 1'b1) n_abort++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_meas(input int c, input int g, input logic sat, input logic up);
    @(posedge pclk);
    meas <= '{cap: c[17:0], cond: g[17:0], amp_sat: sat, auto_up: up, auto_down: 1'b0};
    @(posedge pclk);
    meas.auto_up <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset;
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat, 32'h0000_0200);
    chk(rerr, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0);
    chk(rerr, 32'h1);
  endtask

  task automatic t_manual;
    int i;
    for (i = 1; i <= 4; i++) begin
      op.press(0, 5, 1'b0);
      chk(range_sel, i % 4);
    end
    chk(n_clr, 32'd4);
    chk(n_abort, 32'd4);
  endtask

  task automatic t_atten;
    repeat (3) op.press(0, 5, 1'b0);
    op.press(0, 5, 1'b1);
    chk(panel.atten_led, 32'h1);
    chk(ctl.scale_x10, 32'h1);
    chk(range_sel, 32'h4);
    op.press(0, 5, 1'b0);
    chk(range_sel, 32'h1);
    apb(1'b1, 12'h000, 32'h0000_0029);
    repeat (3) @(posedge pclk);
    chk(panel.conflict, 32'h1);
    chk(panel.test_frequency_key_hi_led, 32'h0);
    chk(panel.atten_led, 32'h1);
    apb(1'b1, 12'h004, 32'h0000_0020);
    op.press(1, 5, 1'b0);
    chk(panel.conflict, 32'h1);
    chk(panel.test_frequency_key_hi_led, 32'h0);
    apb(1'b1, 12'h004, 32'h0000_0020);
    op.press(0, 5, 1'b1);
    chk(panel.atten_led, 32'h0);
  endtask

  task automatic t_high;
    int i;
    apb(1'b1, 12'h000, 32'h0000_0009);
    repeat (3) @(posedge pclk);
    chk(panel.test_frequency_key_hi_led, 32'h1);
    chk(range_sel, 32'h1);
    for (i = 0; i < 3; i++) begin
      op.press(0, 5, 1'b0);
      chk(range_sel, (i == 2) ? 32'h1 : i + 2);
    end
    op.press(0, 5, 1'b1);
    chk(panel.conflict, 32'h1);
    chk(panel.atten_led, 32'h0);
    apb(1'b1, 12'h004, 32'h0000_0020);
    op.press(1, 5, 1'b0);
    chk(panel.test_frequency_key_hi_led, 32'h0);
    chk(panel.conflict, 32'h0);
    chk(range_sel, 32'h1);
  endtask

  task automatic t_auto;
    op.press(0, HOLD + 10, 1'b0);
    chk(panel.auto_led, 32'h1);
    apb(1'b1, 12'h000, 32'h0000_0013);
    repeat (3) @(posedge pclk);
    chk(panel.conflict, 32'h1);
    chk(panel.hi_res, 32'h1);
    chk(panel.auto_led, 32'h1);
    apb(1'b1, 12'h004, 32'h0000_0020);
    set_meas(0, 0, 1'b0, 1'b1);
    chk(range_sel, 32'h2);
    set_meas(0, 0, 1'b0, 1'b1);
    set_meas(0, 0, 1'b0, 1'b1);
    chk(range_sel, 32'h3);
    chk(panel.atten_led, 32'h0);
    op.press(0, 5, 1'b0);
    chk(panel.auto_led, 32'h0);
    chk(range_sel, 32'h3);
  endtask

  task automatic t_limits;
    set_meas(22000, 21999, 1'b0, 1'b0);
    chk(panel.cap_display_overflow_message, 32'h1);
    chk(panel.cond_display_overflow_message, 32'h0);
    op.press(2, 5, 1'b0);
    chk(panel.hi_res, 32'h0);
    set_meas(2199, 2200, 1'b0, 1'b0);
    chk(panel.cap_display_overflow_message, 32'h0);
    chk(panel.cond_display_overflow_message, 32'h1);
    op.press(2, 5, 1'b0);
    chk(panel.hi_res, 32'h0);
    op.press(2, 5, 1'b0);
    chk(panel.hi_res, 32'h1);
    apb(1'b1, 12'h000, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk(panel.hi_res, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat, 32'h0000_0002);
    set_meas(-1234, 150, 1'b1, 1'b0);
    chk(panel.overload, 32'h1);
    chk(ctl.readings_valid, 32'h0);
    chk({ctl.bias_hold, ctl.buf_hold}, 32'h3);
    chk(analog_cap, 32'hFFFF_FB2E);
    chk(analog_cond, 32'h0000_0096);
    set_meas(0, 0, 1'b0, 1'b0);
    chk(panel.overload, 32'h0);
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    final_report;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    meas = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_manual;
    t_atten;
    t_high;
    t_auto;
    t_limits;
    final_report;
  end
endmodule
